/* verilog/sldcr_pkg.sv */
// Package: register map, field positions and reset values of the loop delay config slice
package sldcr_pkg;

	// Register count and data width
	localparam int SLDCR_NREG = 5;
	localparam int SLDCR_DW = 8;

	// Register indices inside the slice
	localparam int SLDCR_IDX_BLEED_CTRL = 0;
	localparam int SLDCR_IDX_BLEED_HIGH = 1;
	localparam int SLDCR_IDX_INV_FBDEL = 2;
	localparam int SLDCR_IDX_IOLVL_REFDEL = 3;
	localparam int SLDCR_IDX_AMP_PD = 4;

	// Register offsets on the serial register port
	localparam logic [7:0] SLDCR_OFS_BLEED_CTRL = 8'h15;
	localparam logic [7:0] SLDCR_OFS_BLEED_HIGH = 8'h16;
	localparam logic [7:0] SLDCR_OFS_INV_FBDEL = 8'h17;
	localparam logic [7:0] SLDCR_OFS_IOLVL_REFDEL = 8'h18;
	localparam logic [7:0] SLDCR_OFS_AMP_PD = 8'h19;

	// Reset values
	localparam logic [7:0] SLDCR_RST_BLEED_CTRL = 8'h00;
	localparam logic [7:0] SLDCR_RST_BLEED_HIGH = 8'h00;
	localparam logic [7:0] SLDCR_RST_INV_FBDEL = 8'h00;
	localparam logic [7:0] SLDCR_RST_IOLVL_REFDEL = 8'h00;
	localparam logic [7:0] SLDCR_RST_AMP_PD = 8'h04;
	localparam logic [7:0] SLDCR_RDATA_UNMAPPED = 8'h00;

	// Offset and reset tables, in index order
	localparam logic [7:0] SLDCR_OFS_TABLE [SLDCR_NREG] = '{
		SLDCR_OFS_BLEED_CTRL, SLDCR_OFS_BLEED_HIGH, SLDCR_OFS_INV_FBDEL,
		SLDCR_OFS_IOLVL_REFDEL, SLDCR_OFS_AMP_PD};
	localparam logic [7:0] SLDCR_RST_TABLE [SLDCR_NREG] = '{
		SLDCR_RST_BLEED_CTRL, SLDCR_RST_BLEED_HIGH, SLDCR_RST_INV_FBDEL,
		SLDCR_RST_IOLVL_REFDEL, SLDCR_RST_AMP_PD};

	// Field positions, bleed control register
	localparam int SLDCR_BLEED_LO_MSB = 7;
	localparam int SLDCR_BLEED_LO_LSB = 6;
	localparam int SLDCR_BLEED_POLARITY_BIT = 5;
	localparam int SLDCR_BLEED_EN_BIT = 4;
	localparam int SLDCR_PUMP_I_MSB = 3;
	localparam int SLDCR_PUMP_I_LSB = 0;
	localparam int SLDCR_BLEED_W = 10;

	// Field positions, invert / delay registers
	localparam int SLDCR_INV_BIT = 7;
	localparam int SLDCR_IOLVL_BIT = 7;
	localparam int SLDCR_DELAY_MSB = 6;
	localparam int SLDCR_DELAY_W = 7;

	// Field positions, amplitude / power-down register
	localparam int SLDCR_RSV_MSB = 7;
	localparam int SLDCR_RSV_LSB = 6;
	localparam int SLDCR_AMP_MSB = 5;
	localparam int SLDCR_AMP_LSB = 4;
	localparam int SLDCR_OSC_MUX_DIVIDER_POWERDOWN_BIT = 3;
	localparam int SLDCR_REF_DETECTOR_POWERDOWN_BIT = 2;
	localparam int SLDCR_TEMP_CONVERTER_POWERDOWN_BIT = 1;
	localparam int SLDCR_PD_CALDAC_BIT = 0;

	// Width of the double-buffered bundle: bleed, invert, two delays
	localparam int SLDCR_DBUF_W = SLDCR_BLEED_W + 1 + 2 * SLDCR_DELAY_W;

endpackage

/* verilog/sldcr_dbuf_stage.sv */
// Active copy of double-buffered fields, loaded immediately or on commit
`timescale 1ns/100ps
`default_nettype none
module sldcr_dbuf_stage
	import sldcr_pkg::*;
#(
	parameter int WIDTH = SLDCR_DBUF_W
)
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Staged value and load strobe
	input wire logic [WIDTH-1:0] i_stage,
	input wire logic i_load,
	// Value steering the analog blocks
	output logic [WIDTH-1:0] o_active
);

	// Refuse a zero-width stage
	if (WIDTH < 1)
	begin : g_bad_width
		$error("sldcr_dbuf_stage: WIDTH must be at least 1");
	end

	// Active copy; reset value is all zero like the staged registers
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_active <= '0;
		else if (i_load)
			o_active <= i_stage;
	end

endmodule
`default_nettype wire

/* verilog/sldcr_regs.sv */
// Loop delay and output configuration registers of the clock synthesizer
`timescale 1ns/100ps
`default_nettype none
module sldcr_regs
	import sldcr_pkg::*;
(
	// Clock and asynchronous active-low reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// Register port from the serial interface engine
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Double-buffer control from the serial interface engine
	input wire logic i_dbuf_enable,
	input wire logic i_dbuf_commit,
	// Charge-pump controls
	output logic [3:0] o_pump_current_select,
	output logic [9:0] o_bleed_current,
	output logic o_bleed_polarity,
	output logic o_bleed_enable,
	// Delay and output controls
	output logic o_output_invert,
	output logic [6:0] o_feedback_delay,
	output logic [6:0] o_reference_delay,
	output logic o_io_logic_level,
	output logic [1:0] o_output_amplitude,
	// Block power-downs and reserved bits
	output logic o_osc_mux_divider_powerdown,
	output logic o_ref_detector_powerdown,
	output logic o_temp_converter_powerdown,
	output logic o_caldac_powerdown,
	output logic [1:0] o_reserved_amp_reg_bits
);

	// Synchronised reset: stage and usable copy
	logic rst_meta_n;
	logic rst_n;

	// Staged register contents, what software wrote
	logic [7:0] reg_q [SLDCR_NREG];

	// Per-register write hit
	logic [SLDCR_NREG-1:0] wr_hit;

	// Read decode
	logic rd_any_hit;
	logic [7:0] rd_value;

	// Double-buffer bundle: staged and active
	logic [SLDCR_DBUF_W-1:0] dbuf_stage;
	logic [SLDCR_DBUF_W-1:0] dbuf_active;
	logic dbuf_load;

	// Register fields before the buffer
	logic [9:0] stage_bleed;
	logic stage_invert;
	logic [6:0] stage_fb_delay;
	logic [6:0] stage_ref_delay;

	// Address match, used by write and read decode
	function automatic logic sldcr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		sldcr_hit = (addr == ofs);
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// One storage register per offset
	for (genvar gi = 0; gi < SLDCR_NREG; gi++)
	begin : g_reg
		// Write strobe for this offset
		assign wr_hit[gi] = i_reg_wr && sldcr_hit(i_reg_addr, SLDCR_OFS_TABLE[gi]);

		// Whole byte stored; reserved bits kept as written
		always_ff @(posedge i_sys_clk or negedge rst_n)
		begin
			if (!rst_n)
				reg_q[gi] <= SLDCR_RST_TABLE[gi];
			else if (wr_hit[gi])
				reg_q[gi] <= i_reg_wdata;
		end
	end

	// Read mux over the offsets, unmapped reads zero
	always_comb
	begin
		rd_any_hit = 1'b0;
		rd_value = SLDCR_RDATA_UNMAPPED;
		for (int ri = 0; ri < SLDCR_NREG; ri++)
		begin
			if (sldcr_hit(i_reg_addr, SLDCR_OFS_TABLE[ri]))
			begin
				rd_any_hit = 1'b1;
				rd_value = reg_q[ri];
			end
		end
	end

	// Read data registered, one cycle after the read strobe
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_reg_rdata <= SLDCR_RDATA_UNMAPPED;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
				o_reg_rdata <= rd_any_hit ? rd_value : SLDCR_RDATA_UNMAPPED;
		end
	end

	// Bleed current: low pair in control reg, upper byte next
	assign stage_bleed = {reg_q[SLDCR_IDX_BLEED_HIGH],
		reg_q[SLDCR_IDX_BLEED_CTRL][SLDCR_BLEED_LO_MSB:SLDCR_BLEED_LO_LSB]};
	// Invert and delay fields
	assign stage_invert = reg_q[SLDCR_IDX_INV_FBDEL][SLDCR_INV_BIT];
	assign stage_fb_delay = reg_q[SLDCR_IDX_INV_FBDEL][SLDCR_DELAY_MSB:0];
	assign stage_ref_delay = reg_q[SLDCR_IDX_IOLVL_REFDEL][SLDCR_DELAY_MSB:0];
	assign dbuf_stage = {stage_bleed, stage_invert, stage_fb_delay, stage_ref_delay};

	// Follow writes unless buffering held; commit copies all at once
	assign dbuf_load = !i_dbuf_enable || i_dbuf_commit;

	// Active copy of the double-buffered fields
	sldcr_dbuf_stage #(
		.WIDTH(SLDCR_DBUF_W)
	) u_dbuf (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(rst_n),
		.i_stage(dbuf_stage),
		.i_load(dbuf_load),
		.o_active(dbuf_active)
	);

	// Double-buffered outputs
	assign o_bleed_current = dbuf_active[SLDCR_DBUF_W-1 -: SLDCR_BLEED_W];
	assign o_output_invert = dbuf_active[2*SLDCR_DELAY_W];
	assign o_feedback_delay = dbuf_active[2*SLDCR_DELAY_W-1 -: SLDCR_DELAY_W];
	assign o_reference_delay = dbuf_active[SLDCR_DELAY_W-1:0];

	// Directly applied controls from the bleed control register
	assign o_pump_current_select = reg_q[SLDCR_IDX_BLEED_CTRL][SLDCR_PUMP_I_MSB:SLDCR_PUMP_I_LSB];
	assign o_bleed_polarity = reg_q[SLDCR_IDX_BLEED_CTRL][SLDCR_BLEED_POLARITY_BIT];
	assign o_bleed_enable = reg_q[SLDCR_IDX_BLEED_CTRL][SLDCR_BLEED_EN_BIT];

	// I/O level: 0 selects 1.8 V, 1 selects 3.3 V
	assign o_io_logic_level = reg_q[SLDCR_IDX_IOLVL_REFDEL][SLDCR_IOLVL_BIT];

	// Amplitude and power-down controls
	assign o_output_amplitude = reg_q[SLDCR_IDX_AMP_PD][SLDCR_AMP_MSB:SLDCR_AMP_LSB];
	assign o_osc_mux_divider_powerdown = reg_q[SLDCR_IDX_AMP_PD][SLDCR_OSC_MUX_DIVIDER_POWERDOWN_BIT];
	assign o_ref_detector_powerdown = reg_q[SLDCR_IDX_AMP_PD][SLDCR_REF_DETECTOR_POWERDOWN_BIT];
	assign o_temp_converter_powerdown = reg_q[SLDCR_IDX_AMP_PD][SLDCR_TEMP_CONVERTER_POWERDOWN_BIT];
	assign o_caldac_powerdown = reg_q[SLDCR_IDX_AMP_PD][SLDCR_PD_CALDAC_BIT];
	assign o_reserved_amp_reg_bits = reg_q[SLDCR_IDX_AMP_PD][SLDCR_RSV_MSB:SLDCR_RSV_LSB];

	// Checks, on the synchronised reset
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!rst_n);

	// Write of upper bleed byte reaches the output two cycles on
	property p_bleed_follow;
		(wr_hit[SLDCR_IDX_BLEED_HIGH] && !i_dbuf_enable) ##1 (!wr_hit[SLDCR_IDX_BLEED_HIGH] && !i_dbuf_enable)
			|=> o_bleed_current[9:2] == $past(i_reg_wdata, 2);
	endproperty
	a_bleed_follow: assert property (p_bleed_follow) else $error("bleed upper byte not applied");

	// Buffered fields hold while buffering is on and no commit
	property p_dbuf_hold;
		(i_dbuf_enable && !i_dbuf_commit) |=> $stable(o_bleed_current) && $stable(o_feedback_delay);
	endproperty
	a_dbuf_hold: assert property (p_dbuf_hold) else $error("buffered field moved without commit");

	// Polarity and enable follow a control write next cycle
	property p_pol_en;
		wr_hit[SLDCR_IDX_BLEED_CTRL] |=> o_bleed_polarity == $past(i_reg_wdata[5]) &&
			o_bleed_enable == $past(i_reg_wdata[4]);
	endproperty
	a_pol_en: assert property (p_pol_en) else $error("bleed polarity or enable wrong");

	// Commit copies invert and feedback delay
	property p_commit_inv;
		i_dbuf_commit |=> o_output_invert == $past(stage_invert) && o_feedback_delay == $past(stage_fb_delay);
	endproperty
	a_commit_inv: assert property (p_commit_inv) else $error("commit missed invert or feedback delay");

	// Commit copies reference delay from register 0x18
	property p_commit_ref;
		i_dbuf_commit |=> o_reference_delay == $past(reg_q[SLDCR_IDX_IOLVL_REFDEL][6:0]);
	endproperty
	a_commit_ref: assert property (p_commit_ref) else $error("commit missed reference delay");

	// Level select follows bit 7 of 0x18
	property p_io_level;
		wr_hit[SLDCR_IDX_IOLVL_REFDEL] |=> o_io_logic_level == $past(i_reg_wdata[7]);
	endproperty
	a_io_level: assert property (p_io_level) else $error("io level select wrong");

	// Amplitude and mux power-down follow 0x19
	property p_amp_pd;
		wr_hit[SLDCR_IDX_AMP_PD] |=> o_output_amplitude == $past(i_reg_wdata[5:4]) &&
			o_osc_mux_divider_powerdown == $past(i_reg_wdata[3]);
	endproperty
	a_amp_pd: assert property (p_amp_pd) else $error("amplitude or mux power-down wrong");

	// Right after reset release: detector off, converter on, 0x19 at 0x04
	property p_reset_vals;
		$rose(rst_n) |-> o_ref_detector_powerdown && !o_temp_converter_powerdown &&
			reg_q[SLDCR_IDX_AMP_PD] == SLDCR_RST_AMP_PD && reg_q[SLDCR_IDX_INV_FBDEL] == 8'h00;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	// Write then read of 0x17 returns written byte
	property p_readback;
		(wr_hit[SLDCR_IDX_INV_FBDEL]) ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == SLDCR_OFS_INV_FBDEL)
			|=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("readback differs from write");

	// Read strobe answered by one valid pulse next cycle
	property p_rvalid_pulse;
		1'b1 |=> o_reg_rvalid == $past(i_reg_rd);
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid pulse wrong");

	// Reads outside the slice answer zero
	property p_unmapped_zero;
		(i_reg_rd && (i_reg_addr < SLDCR_OFS_BLEED_CTRL || i_reg_addr > SLDCR_OFS_AMP_PD))
			|=> o_reg_rdata == SLDCR_RDATA_UNMAPPED;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	// Low bleed pair reaches the output two cycles after a control write
	property p_bleed_low;
		(wr_hit[SLDCR_IDX_BLEED_CTRL] && !i_dbuf_enable) ##1 (!wr_hit[SLDCR_IDX_BLEED_CTRL] && !i_dbuf_enable)
			|=> o_bleed_current[1:0] == $past(i_reg_wdata[7:6], 2);
	endproperty
	a_bleed_low: assert property (p_bleed_low) else $error("bleed low pair not applied");

	// Invert and feedback delay follow a write when not buffered
	property p_inv_fb_follow;
		(wr_hit[SLDCR_IDX_INV_FBDEL] && !i_dbuf_enable) ##1 (!wr_hit[SLDCR_IDX_INV_FBDEL] && !i_dbuf_enable)
			|=> o_output_invert == $past(i_reg_wdata[7], 2) &&
			o_feedback_delay == $past(i_reg_wdata[6:0], 2);
	endproperty
	a_inv_fb_follow: assert property (p_inv_fb_follow) else $error("invert or feedback delay not applied");

	// Reference delay follows a write when not buffered
	property p_ref_follow;
		(wr_hit[SLDCR_IDX_IOLVL_REFDEL] && !i_dbuf_enable) ##1
			(!wr_hit[SLDCR_IDX_IOLVL_REFDEL] && !i_dbuf_enable)
			|=> o_reference_delay == $past(i_reg_wdata[6:0], 2);
	endproperty
	a_ref_follow: assert property (p_ref_follow) else $error("reference delay not applied");

	// Invert and reference delay hold while buffering holds them
	property p_dbuf_hold_inv_ref;
		(i_dbuf_enable && !i_dbuf_commit) |=> $stable(o_output_invert) && $stable(o_reference_delay);
	endproperty
	a_dbuf_hold_inv_ref: assert property (p_dbuf_hold_inv_ref) else $error("buffered invert or delay moved");

	// Detector and converter power-downs follow a write
	property p_low_pd;
		wr_hit[SLDCR_IDX_AMP_PD] |=> o_ref_detector_powerdown == $past(i_reg_wdata[2]) &&
			o_temp_converter_powerdown == $past(i_reg_wdata[1]);
	endproperty
	a_low_pd: assert property (p_low_pd) else $error("detector or converter power-down wrong");

	// Main scenarios
	c_commit: cover property (i_dbuf_enable && wr_hit[SLDCR_IDX_INV_FBDEL] ##[1:8] i_dbuf_commit);
	c_bleed_on: cover property (wr_hit[SLDCR_IDX_BLEED_CTRL] ##1 o_bleed_enable && o_bleed_polarity);
	c_unmapped: cover property (i_reg_rd && !rd_any_hit);
	c_rdet_on: cover property ($fell(o_ref_detector_powerdown));

endmodule
`default_nettype wire

/* verif/sldcr_tb.sv */
// Self-checking testbench for the loop delay configuration registers
`timescale 1ns/100ps
`default_nettype none
module testbench
	import sldcr_pkg::*;
;
	// Stimulus and observed nets, named as the ports
	logic i_sys_clk, i_resetn, i_reg_wr, i_reg_rd, i_dbuf_enable, i_dbuf_commit;
	logic [7:0] i_reg_addr, i_reg_wdata;
	wire logic [7:0] o_reg_rdata;
	wire logic [3:0] o_pump_current_select;
	wire logic [9:0] o_bleed_current;
	wire logic [6:0] o_feedback_delay, o_reference_delay;
	wire logic [1:0] o_output_amplitude, o_reserved_amp_reg_bits;
	wire logic o_reg_rvalid, o_bleed_polarity, o_bleed_enable, o_output_invert, o_io_logic_level;
	wire logic o_osc_mux_divider_powerdown, o_ref_detector_powerdown, o_temp_converter_powerdown;
	wire logic o_caldac_powerdown;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] v;

	// Device under test
	sldcr_regs u_dut (.i_sys_clk, .i_resetn, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
		.o_reg_rdata, .o_reg_rvalid, .i_dbuf_enable, .i_dbuf_commit, .o_pump_current_select,
		.o_bleed_current, .o_bleed_polarity, .o_bleed_enable, .o_output_invert, .o_feedback_delay,
		.o_reference_delay, .o_io_logic_level, .o_output_amplitude, .o_osc_mux_divider_powerdown,
		.o_ref_detector_powerdown, .o_temp_converter_powerdown, .o_caldac_powerdown,
		.o_reserved_amp_reg_bits);

	// 50 MHz clock
	initial
	begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	// Hang guard, far above the expected run
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			conclude();
		end
	end

	// Counts and verdict
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One comparison
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("BAD %0t got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask

	// Single write strobe, driven at the falling edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_sys_clk);
		i_reg_wr = 1'b0;
	endtask

	// Single read strobe; answer sampled one cycle later
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge i_sys_clk);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(negedge i_sys_clk);
		i_reg_rd = 1'b0;
		chk(10'(o_reg_rvalid), 10'h001);
		chk(10'(o_reg_rdata), 10'(exp));
	endtask

	// Reset contents of all five registers and reset-driven outputs
	task automatic t_reset_values();
		logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
		for (int i = 0; i < 5; i++)
			rd_reg(8'h15 + 8'(i), rst[i]);
		chk(10'(o_ref_detector_powerdown), 10'h001);
		chk(10'(o_temp_converter_powerdown), 10'h000);
	endtask

	// Direct fields, write and readback, buffering off
	task automatic t_direct();
		logic [7:0] pat [2] = '{8'hb9, 8'h46};
		for (int i = 0; i < 2; i++)
		begin
			v = pat[i];
			wr_reg(8'h15, v);
			chk(10'(o_pump_current_select), 10'(v[3:0]));
			chk(10'(o_bleed_polarity), 10'(v[5]));
			chk(10'(o_bleed_enable), 10'(v[4]));
			rd_reg(8'h15, v);
		end
		for (int i = 0; i < 4; i++)
		begin
			// Amplitude codes 00..11, reserved bits at required zero
			v = {2'b00, 2'(i), i[0], i[1], ~i[0], i[1]};
			wr_reg(8'h19, v);
			chk(10'(o_output_amplitude), 10'(i));
			chk(10'(o_osc_mux_divider_powerdown), 10'(v[3]));
			chk(10'(o_ref_detector_powerdown), 10'(v[2]));
			chk(10'(o_temp_converter_powerdown), 10'(v[1]));
			chk(10'(o_caldac_powerdown), 10'(v[0]));
			chk(10'(o_reserved_amp_reg_bits), 10'h000);
			rd_reg(8'h19, v);
		end
	endtask

	// Buffered fields following writes, buffering off
	task automatic t_follow();
		wr_reg(8'h16, 8'ha5);
		wr_reg(8'h17, 8'h85);
		wr_reg(8'h18, 8'hc1);
		chk(10'(o_io_logic_level), 10'h001);
		@(negedge i_sys_clk);
		chk(o_bleed_current, 10'h295);
		chk(10'(o_output_invert), 10'h001);
		chk(10'(o_feedback_delay), 10'h005);
		chk(10'(o_reference_delay), 10'h041);
		wr_reg(8'h17, 8'h7f);
		wr_reg(8'h18, 8'h00);
		chk(10'(o_io_logic_level), 10'h000);
		chk(10'(o_output_invert), 10'h000);
		chk(10'(o_feedback_delay), 10'h07f);
	endtask

	// Buffered fields held until commit
	task automatic t_commit();
		@(negedge i_sys_clk);
		i_dbuf_enable = 1'b1;
		wr_reg(8'h15, 8'h80);
		wr_reg(8'h16, 8'h3c);
		wr_reg(8'h17, 8'h8a);
		wr_reg(8'h18, 8'h12);
		@(negedge i_sys_clk);
		chk(o_bleed_current, 10'h295);
		chk(10'(o_output_invert), 10'h000);
		chk(10'(o_feedback_delay), 10'h07f);
		chk(10'(o_reference_delay), 10'h000);
		chk(10'(o_pump_current_select), 10'h000);
		rd_reg(8'h17, 8'h8a);
		i_dbuf_commit = 1'b1;
		@(negedge i_sys_clk);
		i_dbuf_commit = 1'b0;
		@(negedge i_sys_clk);
		chk(o_bleed_current, 10'h0f2);
		chk(10'(o_output_invert), 10'h001);
		chk(10'(o_feedback_delay), 10'h00a);
		chk(10'(o_reference_delay), 10'h012);
		i_dbuf_enable = 1'b0;
	endtask

	// Write then read of the same place on consecutive edges
	task automatic t_back_to_back();
		@(negedge i_sys_clk);
		i_reg_addr = 8'h17;
		i_reg_wdata = 8'h85;
		i_reg_wr = 1'b1;
		@(negedge i_sys_clk);
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b1;
		@(negedge i_sys_clk);
		i_reg_rd = 1'b0;
		chk(10'(o_reg_rvalid), 10'h001);
		chk(10'(o_reg_rdata), 10'h085);
	endtask

	// Unmapped places and a reset in mid-run
	task automatic t_unmapped_reset();
		wr_reg(8'h14, 8'hff);
		wr_reg(8'h1a, 8'hff);
		rd_reg(8'h14, 8'h00);
		rd_reg(8'h1a, 8'h00);
		rd_reg(8'h16, 8'h3c);
		@(negedge i_sys_clk);
		i_resetn = 1'b0;
		#2;
		chk(10'(o_ref_detector_powerdown), 10'h001);
		chk(10'(o_feedback_delay), 10'h000);
		repeat (2) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		rd_reg(8'h19, 8'h04);
		rd_reg(8'h17, 8'h00);
	endtask

	// Main sequence
	initial
	begin
		i_resetn = 1'b0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wdata = 8'h00;
		i_dbuf_enable = 1'b0;
		i_dbuf_commit = 1'b0;
		repeat (3) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		t_reset_values();
		t_direct();
		t_follow();
		t_commit();
		t_back_to_back();
		t_unmapped_reset();
		conclude();
	end
endmodule
`default_nettype wire
